// File: dpr_port_logic.sv
/*
 * Port logic of a 4K x 9 dual-port synchronous memory: input
 * registers, select and power down, writes, reads with pipelined or
 * flow-through latency, input register advance and output enable.
 * Assumes all port pins are asynchronous to clock, which runs much
 * faster than either port clock so each port edge is seen.
 */
// Notes on behaviour
// - Left port reads pipelined; right port pipelined when strap high, else flow.
// - Port registers load only on that port's rising clock edge.
// - Output enable high forces data pins undriven, without a port edge.
// - Select sampled high deselects, releases pins and powers the port down.
// - Pipelined port needs two selected edges before driving again.
// - Select and read/write low at an edge start a write.
// - A write begun at one edge ends by the port's next edge.
// - Write strobe derives from the rising edge only, not clock duty.
// - Selected read with output enable low returns data, latency one flow-through, two pipelined.
// - Advance high holds address and data registers; low loads them.
// - Pipelined pin data follows the read registered the cycle before; flow-through data, the same cycle's.
// - Both ports read and write the array at the same time.
// - Words are nine bits; parity bit stored only, never made or checked.
// - Array holds 4K words addressed by a twelve-bit register.
`timescale 1ns/1ns
`default_nettype none
module dpr_port_logic
    import dpr_pkg::*;
(
    // System clock and reset
    input wire logic clock,
    input wire logic rst,
    // Left port pins
    input wire logic left_port_clock,
    input wire logic left_select_n,
    input wire logic left_read_write,
    input wire logic left_output_enable_n,
    input wire logic left_input_register_advance_n,
    input wire logic [dpr_pkg::ADDR_W-1:0] left_address,
    input wire logic [dpr_pkg::DATA_W-1:0] left_data_pins_in,
    output logic [dpr_pkg::DATA_W-1:0] left_data_pins_out,
    output logic left_data_pins_oe,
    output logic left_power_down,
    // Right port pins
    input wire logic right_port_clock,
    input wire logic right_select_n,
    input wire logic right_read_write,
    input wire logic right_output_enable_n,
    input wire logic right_input_register_advance_n,
    input wire logic [dpr_pkg::ADDR_W-1:0] right_address,
    input wire logic [dpr_pkg::DATA_W-1:0] right_data_pins_in,
    output logic [dpr_pkg::DATA_W-1:0] right_data_pins_out,
    output logic right_data_pins_oe,
    output logic right_power_down,
    // Right port read mode strap
    input wire logic right_port_read_mode_strap
);
    import dpr_pkg::*;

    // Shared array, nine bits per word, parity bit just stored
    logic [DATA_W-1:0] mem_q [DEPTH];

    // Per-port state, one element per port
    dpr_smp_t pin_vec [NPORTS];
    logic [ADDR_W-1:0] addr_q [NPORTS];
    logic [DATA_W-1:0] din_q [NPORTS];
    logic [DATA_W-1:0] dout_q [NPORTS];
    logic wr_pend_q [NPORTS];
    logic oe_pin_q [NPORTS];
    logic pd_q [NPORTS];

    // Strap sampler
    logic [SYNC_STAGES-1:0] strap_s_q;
    logic strap_f_q;

    // Gather each port's pins into one sampled vector
    assign pin_vec[LEFT] = {left_port_clock, left_select_n, left_read_write,
        left_output_enable_n, left_input_register_advance_n, left_address,
        left_data_pins_in};
    assign pin_vec[RIGHT] = {right_port_clock, right_select_n,
        right_read_write, right_output_enable_n,
        right_input_register_advance_n, right_address, right_data_pins_in};

    // Strap passes three stages, accepted once last two agree
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_s_q <= '0;
            strap_f_q <= 1'b0;
        end else begin
            strap_s_q <= {strap_s_q[SYNC_STAGES-2:0],
                right_port_read_mode_strap};
            if (strap_s_q[1] == strap_s_q[2]) begin
                strap_f_q <= strap_s_q[2];
            end
        end
    end

    // Array writes from both ports; each port writes on its own pulse
    always_ff @(posedge clock) begin
        for (int p = 0; p < NPORTS; p++) begin
            if (wr_pend_q[p]) begin
                mem_q[addr_q[p]] <= din_q[p];
            end
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++) begin : g_port
            dpr_smp_t s1_q, s2_q, s3_q;
            logic clk_f_q, sel_f_q, oe_f_q;
            logic port_edge, sel_n, rd_now, wr_now, pipe_mode;
            logic [1:0] sel_cnt_q, sel_cnt_d;
            logic rd_last_q, rd_pend_q, drive_q;
            logic [DATA_W-1:0] rd_q;

            // Three-stage sampler of all port pins
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    s1_q <= '0;
                    s2_q <= '0;
                    s3_q <= '0;
                end else begin
                    s1_q <= pin_vec[gp];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            // Filtered levels of port clock, select and output enable
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    clk_f_q <= 1'b0;
                    oe_f_q <= 1'b1;
                    sel_f_q <= 1'b1;
                end else begin
                    if (s2_q[SMP_CLK] == s3_q[SMP_CLK]) begin
                        clk_f_q <= s3_q[SMP_CLK];
                    end
                    if (s2_q[SMP_OE_N] == s3_q[SMP_OE_N]) begin
                        oe_f_q <= s3_q[SMP_OE_N];
                    end
                    if (s2_q[SMP_SEL_N] == s3_q[SMP_SEL_N]) begin
                        sel_f_q <= s3_q[SMP_SEL_N];
                    end
                end
            end

            // Port rising edge seen once two stages agree high
            assign port_edge = s2_q[SMP_CLK] & s3_q[SMP_CLK]
                & ~clk_f_q;
            assign sel_n = s3_q[SMP_SEL_N];
            assign rd_now = ~sel_n & s3_q[SMP_RW];
            assign wr_now = ~sel_n & ~s3_q[SMP_RW];
            assign pipe_mode = (gp == LEFT) | strap_f_q;
            assign sel_cnt_d = sel_n ? SEL_CNT_RST
                : (sel_cnt_q == PIPE_RESEL_EDGES) ? sel_cnt_q
                : sel_cnt_q + 2'h1;

            // Address and data registers, held while advance is high
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    addr_q[gp] <= '0;
                    din_q[gp] <= '0;
                end else if (port_edge && !s3_q[SMP_ADV_N]) begin
                    addr_q[gp] <= s3_q[SMP_ADDR_LSB +: ADDR_W];
                    din_q[gp] <= s3_q[SMP_DIN_LSB +: DATA_W];
                end
            end

            // Registered controls and one-cycle access pulses
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    sel_cnt_q <= SEL_CNT_RST;
                    rd_last_q <= 1'b0;
                    rd_pend_q <= 1'b0;
                    wr_pend_q[gp] <= 1'b0;
                    pd_q[gp] <= 1'b1;
                end else begin
                    rd_pend_q <= port_edge & rd_now;
                    wr_pend_q[gp] <= port_edge & wr_now;
                    if (port_edge) begin
                        sel_cnt_q <= sel_cnt_d;
                        rd_last_q <= rd_now;
                        pd_q[gp] <= sel_n;
                    end
                end
            end

            // Array read, taken the cycle after the edge
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    rd_q <= '0;
                end else if (rd_pend_q) begin
                    rd_q <= mem_q[addr_q[gp]];
                end
            end

            // Output data and drive state
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    dout_q[gp] <= '0;
                    drive_q <= 1'b0;
                end else if (port_edge) begin
                    if (pipe_mode) begin
                        // Prior read shows now, after select recovery
                        dout_q[gp] <= rd_q;
                        drive_q <= rd_last_q & ~sel_n
                            & (sel_cnt_d == PIPE_RESEL_EDGES);
                    end else begin
                        drive_q <= 1'b0;
                    end
                end else if (rd_pend_q && !pipe_mode) begin
                    // Flow-through data follows the same edge
                    dout_q[gp] <= mem_q[addr_q[gp]];
                    drive_q <= 1'b1;
                end
            end

            // Pin enable, forced off by output enable at any time
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    oe_pin_q[gp] <= 1'b0;
                end else begin
                    oe_pin_q[gp] <= drive_q & ~oe_f_q
                        & ~sel_f_q;
                end
            end
        end
    endgenerate

    // Pin outputs, all straight from flip-flops
    assign left_data_pins_out = dout_q[LEFT];
    assign left_data_pins_oe = oe_pin_q[LEFT];
    assign left_power_down = pd_q[LEFT];
    assign right_data_pins_out = dout_q[RIGHT];
    assign right_data_pins_oe = oe_pin_q[RIGHT];
    assign right_power_down = pd_q[RIGHT];
endmodule
`default_nettype wire

// File: dpr_pkg.sv
/*
 * Constants shared by the dual-port memory port logic: widths, depth,
 * input sampler layout and select recovery count.
 * Assumes a single system clock that oversamples both port clocks.
 */
package dpr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 9;
    localparam int DEPTH = 4096;
    localparam int NPORTS = 2;
    localparam int SYNC_STAGES = 3;
    // Sampled input vector layout, one per port
    localparam int SMP_DIN_LSB = 0;
    localparam int SMP_ADDR_LSB = DATA_W;
    localparam int SMP_ADV_N = DATA_W + ADDR_W;
    localparam int SMP_OE_N = SMP_ADV_N + 1;
    localparam int SMP_RW = SMP_ADV_N + 2;
    localparam int SMP_SEL_N = SMP_ADV_N + 3;
    localparam int SMP_CLK = SMP_ADV_N + 4;
    localparam int SMP_W = SMP_CLK + 1;
    // Consecutive selected edges needed before pipelined output returns
    localparam logic [1:0] PIPE_RESEL_EDGES = 2'h2;
    localparam logic [1:0] SEL_CNT_RST = 2'h0;
    localparam int LEFT = 0;
    localparam int RIGHT = 1;
    typedef logic [SMP_W-1:0] dpr_smp_t;
endpackage

// File: dpr_host.sv
/* Host controller model that drives one memory port.
 * Assumes its port clock runs well below the system clock. */
`timescale 1ns/1ns
`default_nettype none
module dpr_host #(
    parameter int HALF = 80
) (
    // Pins toward the port
    output logic port_clock,
    output logic select_n,
    output logic read_write,
    output logic output_enable_n,
    output logic advance_n,
    output logic [dpr_pkg::ADDR_W-1:0] address,
    output logic [dpr_pkg::DATA_W-1:0] wdata,
    // Pins from the port
    input wire logic [dpr_pkg::DATA_W-1:0] rdata,
    input wire logic drive
);
    import dpr_pkg::*;
    // Idle pins, then a port clock once reset is over
    initial begin
        {port_clock, select_n, read_write} = 3'h3;
        {output_enable_n, advance_n} = 2'h0;
        {address, wdata} = '0;
        #300;
        forever #HALF port_clock = ~port_clock;
    end
    // One port cycle: sample the pins, set up the next rising edge
    task automatic op(input logic [2:0] c,
        input logic [ADDR_W+DATA_W-1:0] w,
        output logic [DATA_W-1:0] q, output logic v);
        @(negedge port_clock);
        q = rdata;
        v = drive;
        {select_n, read_write, advance_n} = c;
        address = w[DATA_W+:ADDR_W];
        wdata = read_write ? ~wdata : w[DATA_W-1:0]; // No stale word
        @(posedge port_clock);
    endtask
endmodule
`default_nettype wire

// File: dpr_chk.sv
/* Port-level checker for the dual-port logic, bound to its top.
 * Assumes port pins hold steady for several system clocks. */
`timescale 1ns/1ns
`default_nettype none
module dpr_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Left port
    input wire logic left_port_clock,
    input wire logic left_select_n,
    input wire logic left_output_enable_n,
    input wire logic [dpr_pkg::DATA_W-1:0] left_data_pins_out,
    input wire logic left_data_pins_oe,
    input wire logic left_power_down,
    // Right port
    input wire logic right_output_enable_n,
    input wire logic right_data_pins_oe
);
    import dpr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Pin release, select and power down
    a_oe_gates_left: assert property (left_output_enable_n [*7]
        |-> !left_data_pins_oe) else $error("left pins not released");
    a_oe_gates_right: assert property (right_output_enable_n [*7]
        |-> !right_data_pins_oe) else $error("right pins not released");
    a_sel_gates_pins: assert property (left_select_n [*7]
        |-> !left_data_pins_oe) else $error("deselected port drives");
    a_pd_cause: assert property ($rose(left_power_down)
        |-> left_select_n) else $error("power down while selected");
    a_pd_quiet: assert property (left_power_down
        && $past(left_power_down) |-> !left_data_pins_oe)
        else $error("powered down port drives");
    a_resel_waits: assert property ($fell(left_power_down)
        |-> !left_data_pins_oe [*8]) else $error("drive too soon");
    a_drive_cause: assert property ($rose(left_data_pins_oe)
        |-> !left_select_n && !left_output_enable_n)
        else $error("drive without cause");
    a_data_at_edge: assert property ($changed(left_data_pins_out)
        |-> left_port_clock) else $error("data moved off port edge");
    // Main scenarios
    cover property ($rose(left_data_pins_oe));
    cover property ($fell(left_power_down));
    cover property ($rose(right_data_pins_oe));
endmodule
bind dpr_port_logic dpr_chk u_chk (.*);
`default_nettype wire

// File: tb.sv
/* Self-checking bench for the dual-port port logic.
 * Assumes the host models and the bound checker are compiled too. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    num_errors++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb;
    import dpr_pkg::*;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
    } dpr_row_t;
    // Address beside the word it reads back
    dpr_row_t rows [4] = '{'{12'h000, 9'h1FF}, '{12'hFFF, 9'h100},
        '{12'h555, 9'h0AA}, '{12'hAAA, 9'h055}};
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic clock, rst, strap, lck, lsn, lrw, loen, ladv, rck, rsn, rrw;
    logic roen, radv, loe, roe, lpd, rpd, v;
    logic [ADDR_W-1:0] la, ra;
    logic [DATA_W-1:0] ld, rd, lo, ro, q;
    dpr_host #(.HALF(80)) host_l (.port_clock(lck), .select_n(lsn),
        .read_write(lrw), .output_enable_n(loen), .advance_n(ladv),
        .address(la), .wdata(ld), .rdata(lo), .drive(loe));
    dpr_host #(.HALF(100)) host_r (.port_clock(rck), .select_n(rsn),
        .read_write(rrw), .output_enable_n(roen), .advance_n(radv),
        .address(ra), .wdata(rd), .rdata(ro), .drive(roe));
    dpr_port_logic dut (.clock(clock), .rst(rst), .left_port_clock(lck),
        .left_select_n(lsn), .left_read_write(lrw),
        .left_output_enable_n(loen), .left_input_register_advance_n(ladv),
        .left_address(la), .left_data_pins_in(ld), .left_data_pins_out(lo),
        .left_data_pins_oe(loe), .left_power_down(lpd),
        .right_port_clock(rck), .right_select_n(rsn),
        .right_read_write(rrw), .right_output_enable_n(roen),
        .right_input_register_advance_n(radv), .right_address(ra),
        .right_data_pins_in(rd), .right_data_pins_out(ro),
        .right_data_pins_oe(roe), .right_power_down(rpd),
        .right_port_read_mode_strap(strap));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Read every row on one port; results lag by the port latency
    task automatic rd_pass(input logic p, input int lag);
        logic [DATA_W:0] e;
        for (int i = 0; i < 6; i++) begin
            if (p) host_r.op(3'h2, rows[i % 4], q, v);
            else host_l.op(3'h2, rows[i % 4], q, v);
            e = {1'h1, rows[(i + 4 - lag) % 4].d};
            if (i >= lag) `CHK("read", e, {v, q})
        end
    endtask
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst, strap} = 2'h2;
        repeat (10) @(posedge clock);
        @(negedge clock) rst = 1'h0;
        repeat (2) @(negedge clock);
        `CHK("reset", 4'hA, {lpd, loe, rpd, roe})
        // Both ports write at once, then every read mode
        fork
            for (int i = 0; i < 2; i++) host_l.op(3'h0, rows[i], q, v);
            for (int i = 2; i < 4; i++) host_r.op(3'h0, rows[i], q, v);
        join
        rd_pass(1'h1, 1);
        strap = 1'h1;
        rd_pass(1'h1, 2);
        rd_pass(1'h0, 2);
        // Held input registers repeat the earlier write
        host_l.op(3'h0, {12'h010, 9'h011}, q, v);
        host_l.op(3'h1, {rows[0].a, 9'h0F0}, q, v);
        host_l.op(3'h2, rows[0], q, v);
        repeat (2) host_l.op(3'h2, 21'h002000, q, v);
        `CHK("held write", {1'h1, rows[0].d}, {v, q})
        host_l.op(3'h2, 21'h002000, q, v);
        `CHK("held addr", 10'h211, {v, q})
        // Output enable between port edges
        @(negedge clock) host_l.output_enable_n = 1'h1;
        host_r.output_enable_n = 1'h1;
        repeat (8) @(negedge clock);
        `CHK("oe off", 2'h0, {loe, roe})
        host_l.output_enable_n = 1'h0;
        host_r.output_enable_n = 1'h0;
        repeat (6) @(negedge clock);
        `CHK("oe on", 2'h3, {loe, roe})
        // Deselect, then two selected edges before driving
        host_l.op(3'h6, 21'h002000, q, v);
        host_l.op(3'h2, 21'h002000, q, v);
        `CHK("deselect", 2'h2, {lpd, v})
        host_l.op(3'h2, 21'h002000, q, v);
        `CHK("reselect", 1'h0, v)
        host_l.op(3'h2, 21'h002000, q, v);
        `CHK("resumed", 10'h211, {v, q})
        // Rewrite the word after the idle cycle, then read it back
        host_l.op(3'h0, 21'h0021AB, q, v);
        repeat (3) host_l.op(3'h2, 21'h002000, q, v);
        `CHK("rewrite", 10'h3AB, {v, q})
        report_and_stop();
    end
endmodule
`default_nettype wire
